/* File: core/pas_pkg.sv */
// package: register map, field layout and timing constants for the pwm auto-shutdown block
package pas_pkg;
	// register addresses (none printed, chosen locally)
	localparam logic [3:0] ADDR_AUTO_SHUTDOWN = 4'h0;
	localparam logic [3:0] ADDR_DEADBAND      = 4'h1;
	localparam logic [3:0] ADDR_MODE          = 4'h2;
	localparam logic [3:0] ADDR_PERIOD        = 4'h3;
	localparam logic [3:0] ADDR_DUTY          = 4'h4;
	localparam logic [3:0] ADDR_STATUS        = 4'h5;
	localparam logic [3:0] ADDR_POWER         = 4'h6;

	// auto_shutdown_control fields
	localparam int ASE_BIT   = 7;
	localparam int SRC_HI    = 6;
	localparam int SRC_LO    = 4;
	localparam int PSAC_HI   = 3;
	localparam int PSAC_LO   = 2;
	localparam int PSBD_HI   = 1;
	localparam int PSBD_LO   = 0;
	// deadband_restart_control fields
	localparam int RSEN_BIT  = 7;
	localparam int DB_HI     = 6;
	// pwm_mode_control fields
	localparam int CFG_HI    = 7;
	localparam int CFG_LO    = 6;
	localparam int DCLO_HI   = 5;
	localparam int DCLO_LO   = 4;
	localparam int POL_AC    = 1;
	localparam int POL_BD    = 0;
	localparam int PWMEN_HI  = 3;
	localparam int PWMEN_LO  = 2;
	// status register fields
	localparam int ST_TMRF   = 0;
	localparam int ST_CLKF   = 1;
	// power register fields
	localparam int PW_SLEEP  = 0;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] PWM_ENABLE_CODE = 2'h3;

	// source select codes: bit0 comp1, bit1 comp2, bit2 fault
	localparam int SRC_C1    = 0;
	localparam int SRC_C2    = 1;
	localparam int SRC_FLT   = 2;

	// shutdown pin state codes
	localparam logic [1:0] PSS_LOW  = 2'h0;
	localparam logic [1:0] PSS_HIGH = 2'h1;

	// output configurations
	typedef enum logic [1:0] {
		CFG_SINGLE  = 2'b00,
		CFG_FWD     = 2'b01,
		CFG_HALF    = 2'b10,
		CFG_REV     = 2'b11
	} pas_cfg_e;

	// instruction cycle is four oscillator periods
	localparam int TCY_OSC   = 4;
	localparam int TCY_W     = 2;
	localparam logic [1:0] TCY_LAST = 2'(TCY_OSC - 1);
endpackage : pas_pkg

/* File: core/pas_regbank.sv */
// register bank holding the period, duty and mode bytes with registered read data
`timescale 1ns/10ps
module pas_regbank
	import pas_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [3:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic [3:0] rd_addr,
	output logic      [7:0] rd_data,
	output logic      [7:0] period_q,
	output logic      [7:0] duty_q,
	output logic      [7:0] mode_q
);
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			period_q <= REG_RESET;
			duty_q   <= REG_RESET;
			mode_q   <= REG_RESET; // [R22]
		end else if (wr_en) begin
			if (wr_addr == ADDR_PERIOD) period_q <= wr_data;
			if (wr_addr == ADDR_DUTY)   duty_q   <= wr_data;
			if (wr_addr == ADDR_MODE)   mode_q   <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= REG_RESET;
		end else begin
			unique case (rd_addr)
				ADDR_PERIOD: rd_data <= period_q;
				ADDR_DUTY:   rd_data <= duty_q;
				ADDR_MODE:   rd_data <= mode_q;
				default:     rd_data <= REG_RESET;
			endcase
		end
	end
endmodule : pas_regbank

/* File: core/pas_top.sv */
// pwm auto-shutdown, auto-restart, dead-band and output stage
//
// Overview of operation
// [R1] three-bit source select: comparators, fault, combinations; zero disables shutdown
// [R2] low level on the selected fault input is a shutdown event
// [R3] shutdown event forces the pins to shutdown states without a clock; here the pins are registered and take them on the next edge
// [R4] per pair: 1x tri-state, 01 drive high, 00 drive low
// [R5] hardware sets status bit 7 on an event; set bit holds shutdown states
// [R6] auto-restart: bit stays while cause persists, clears itself after
// [R7] no auto-restart: bit stays until software clears it
// [R8] bit set at period start holds shutdown for that period; resume next period
// [R9] software writes to the status bit ignored while shutdown cause active
// [R10] comparator sources are levels; bit not clearable while they persist
// [R11] writing one to the status bit forces shutdown like a hardware event
// [R12] dead-band bit 7 enables auto-restart; else software must clear status
// [R13] low seven dead-band bits hold the half-bridge delay count
// [R14] mode bits 1 and 0 select polarity of pair a/c and pair b/d
// [R15] software picks polarity before enabling pin drivers
// [R16] software lets one full cycle pass before enabling pin drivers
// [R17] period timer flag sets as the second period begins
// [R18] software sequence: clear, configure, wait, set, clear after overflow
// [R19] sleep freezes timer and state; outputs keep their values
// [R20] idle keeps primary clock; other modes clock timer from selected clock
// [R21] clock failure switches to internal oscillator and sets clock-fail flag
// [R22] any reset returns registers to zero
// [R23] dead-band delays inactive-to-active edges in instruction cycles
// [R24] dead-band longer than duty keeps that output inactive all cycle
// [R25] override combinational from sources; status bit latched next edge
`timescale 1ns/10ps
module pas_top
	import pas_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       fault_input_n,
	input  wire logic       comp1_out,
	input  wire logic       comp2_out,
	input  wire logic       clock_fail,
	output logic            pwm_out_a,
	output logic            pwm_out_b,
	output logic            pwm_out_c,
	output logic            pwm_out_d,
	output logic            pwm_oe_a,
	output logic            pwm_oe_b,
	output logic            pwm_oe_c,
	output logic            pwm_oe_d,
	output logic            period_timer_flag,
	output logic            clock_fail_flag,
	output logic            use_internal_osc
);
	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	function automatic logic cause_of(input logic [2:0] sel, input logic c1, input logic c2, input logic f_n);
		cause_of = (sel[SRC_C1] & c1) | (sel[SRC_C2] & c2) | (sel[SRC_FLT] & ~f_n); // [R1] [R2]
	endfunction : cause_of

	function automatic logic pss_level(input logic [1:0] pss);
		pss_level = (pss == PSS_HIGH); // [R4]
	endfunction : pss_level

	function automatic logic pss_drive(input logic [1:0] pss);
		pss_drive = ~pss[1]; // [R4]
	endfunction : pss_drive

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0] as_ctl_q;
	logic [7:0] db_ctl_q;
	logic       sleep_q;
	logic       tmr_flag_q;
	logic       clk_fail_q;
	logic [7:0] period_q;
	logic [7:0] duty_q;
	logic [7:0] mode_q;
	logic       period_timer_flag_d;

	logic       wr_as;
	logic       wr_db;
	logic       cause;
	logic       hold_period_q;
	logic       running;

	assign wr_as = reg_wr && (reg_addr == ADDR_AUTO_SHUTDOWN);
	assign wr_db = reg_wr && (reg_addr == ADDR_DEADBAND);
	assign running = ~sleep_q; // [R19]

	// comparator and fault sources are levels; cause is purely combinational
	assign cause = cause_of(as_ctl_q[SRC_HI:SRC_LO], comp1_out, comp2_out, fault_input_n); // [R10]

	pas_regbank u_bank (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.wr_addr  (reg_addr),
		.wr_data  (reg_wdata),
		.wr_en    (reg_wr),
		.rd_addr  (reg_addr),
		.rd_data  (),
		.period_q (period_q),
		.duty_q   (duty_q),
		.mode_q   (mode_q)
	);

	// ---------------------------------------------------------------
	// auto-shutdown control and status bit
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			as_ctl_q <= REG_RESET; // [R22]
		end else begin
			if (wr_as)
				as_ctl_q[SRC_HI:0] <= reg_wdata[SRC_HI:0];
			if (running && cause)
				as_ctl_q[ASE_BIT] <= 1'b1; // [R5] [R25]
			else if (wr_as && !cause)
				as_ctl_q[ASE_BIT] <= reg_wdata[ASE_BIT]; // [R7] [R9] [R11]
			else if (running && db_ctl_q[RSEN_BIT])
				as_ctl_q[ASE_BIT] <= 1'b0; // [R6] [R12]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			db_ctl_q <= REG_RESET; // [R22]
		else if (wr_db)
			db_ctl_q <= reg_wdata; // [R13]
	end

	// sleep is a software bit here; wake is a write of zero
	always_ff @(posedge sys_clk) begin
		if (rst)
			sleep_q <= 1'b0;
		else if (reg_wr && reg_addr == ADDR_POWER)
			sleep_q <= reg_wdata[PW_SLEEP];
	end

	// ---------------------------------------------------------------
	// clock failure
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			clk_fail_q       <= 1'b0;
			use_internal_osc <= 1'b0;
		end else begin
			if (clock_fail) begin
				clk_fail_q       <= 1'b1; // [R21]
				use_internal_osc <= 1'b1; // [R21]
			end else if (reg_wr && reg_addr == ADDR_STATUS && !reg_wdata[ST_CLKF]) begin
				clk_fail_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// period timer and instruction-cycle prescale
	// ---------------------------------------------------------------
	// timer ticks once per instruction cycle; in idle the same clock keeps running
	logic [TCY_W-1:0] tcy_q;
	logic [7:0]       tmr_q;
	logic             tick;
	logic             period_start;
	logic             first_done_q;
	logic             pwm_en;

	// timer held while the pwm is off, so the first flag marks a real pwm period
	assign pwm_en       = (mode_q[PWMEN_HI:PWMEN_LO] == PWM_ENABLE_CODE);
	assign tick         = running && pwm_en && (tcy_q == TCY_LAST); // [R17] [R20] [R23]
	assign period_start = tick && (tmr_q == period_q);

	always_ff @(posedge sys_clk) begin
		if (rst)
			tcy_q <= '0;
		else if (running)
			tcy_q <= tcy_q + TCY_W'(1); // [R19]
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			tmr_q <= '0;
		else if (period_start)
			tmr_q <= '0;
		else if (tick)
			tmr_q <= tmr_q + 8'h01;
	end

	// flag each period rollover; first one marks the end of the first full cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tmr_flag_q   <= 1'b0;
			first_done_q <= 1'b0;
		end else begin
			if (period_start) begin
				tmr_flag_q   <= 1'b1; // [R17]
				first_done_q <= 1'b1;
			end else if (reg_wr && reg_addr == ADDR_STATUS && !reg_wdata[ST_TMRF]) begin
				tmr_flag_q <= 1'b0;
			end
		end
	end

	// hold shutdown for a whole period once the status bit is seen at its start
	always_ff @(posedge sys_clk) begin
		if (rst)
			hold_period_q <= 1'b1;
		else if (period_start)
			hold_period_q <= as_ctl_q[ASE_BIT]; // [R8]
	end

	// ---------------------------------------------------------------
	// pwm waveform with dead-band
	// ---------------------------------------------------------------
	logic        duty_on;
	logic [7:0]  db_cnt_q;
	logic        prim_q;
	logic        raw_a;
	logic        raw_b;
	logic        raw_c;
	logic        raw_d;
	logic        db_a_ok;
	logic        db_b_ok;
	pas_cfg_e    cfg;

	assign cfg     = pas_cfg_e'(mode_q[CFG_HI:CFG_LO]);
	assign duty_on = (tmr_q < duty_q);

	// counts instruction cycles since the last edge of the primary waveform
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			db_cnt_q <= '0;
			prim_q   <= 1'b0;
		end else if (tick) begin
			prim_q <= duty_on;
			if (duty_on != prim_q)
				db_cnt_q <= '0;
			else if (db_cnt_q != 8'hff)
				db_cnt_q <= db_cnt_q + 8'h01;
		end
	end

	// active edge waits out the delay; a delay past the duty never lets it go active
	assign db_a_ok = (db_cnt_q >= {1'b0, db_ctl_q[DB_HI:0]}); // [R23] [R24]
	assign db_b_ok = db_a_ok;

	always_comb begin
		raw_a = 1'b0;
		raw_b = 1'b0;
		raw_c = 1'b0;
		raw_d = 1'b0;
		unique case (cfg)
			CFG_SINGLE: raw_a = prim_q;
			CFG_HALF: begin
				raw_a = prim_q && db_a_ok; // [R13]
				raw_b = !prim_q && db_b_ok;
			end
			CFG_FWD: begin
				raw_a = 1'b1;
				raw_d = prim_q;
			end
			CFG_REV: begin
				raw_c = 1'b1;
				raw_b = prim_q;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// output stage
	// ---------------------------------------------------------------
	// pins are registered; the override term also uses the live cause so the
	// forced state lands on the very next edge without waiting for the bit
	logic sd_now;
	logic pol_ac;
	logic pol_bd;

	assign sd_now = cause || as_ctl_q[ASE_BIT] || hold_period_q; // [R3] [R5] [R8] [R25]
	assign pol_ac = mode_q[POL_AC]; // [R14]
	assign pol_bd = mode_q[POL_BD]; // [R14]

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
			pwm_out_c <= 1'b0;
			pwm_out_d <= 1'b0;
			pwm_oe_a  <= 1'b0;
			pwm_oe_b  <= 1'b0;
			pwm_oe_c  <= 1'b0;
			pwm_oe_d  <= 1'b0;
		end else if (running) begin // [R19]
			if (!pwm_en) begin
				pwm_oe_a <= 1'b0;
				pwm_oe_b <= 1'b0;
				pwm_oe_c <= 1'b0;
				pwm_oe_d <= 1'b0;
			end else if (sd_now) begin
				pwm_out_a <= pss_level(as_ctl_q[PSAC_HI:PSAC_LO]); // [R4]
				pwm_out_c <= pss_level(as_ctl_q[PSAC_HI:PSAC_LO]);
				pwm_out_b <= pss_level(as_ctl_q[PSBD_HI:PSBD_LO]);
				pwm_out_d <= pss_level(as_ctl_q[PSBD_HI:PSBD_LO]);
				pwm_oe_a  <= pss_drive(as_ctl_q[PSAC_HI:PSAC_LO]);
				pwm_oe_c  <= pss_drive(as_ctl_q[PSAC_HI:PSAC_LO]);
				pwm_oe_b  <= pss_drive(as_ctl_q[PSBD_HI:PSBD_LO]);
				pwm_oe_d  <= pss_drive(as_ctl_q[PSBD_HI:PSBD_LO]);
			end else begin
				pwm_out_a <= raw_a ^ pol_ac;
				pwm_out_c <= raw_c ^ pol_ac;
				pwm_out_b <= raw_b ^ pol_bd;
				pwm_out_d <= raw_d ^ pol_bd;
				pwm_oe_a  <= first_done_q;
				pwm_oe_c  <= first_done_q;
				pwm_oe_b  <= first_done_q;
				pwm_oe_d  <= first_done_q;
			end
		end
	end

	assign period_timer_flag_d = tmr_flag_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			period_timer_flag <= 1'b0;
			clock_fail_flag   <= 1'b0;
		end else begin
			period_timer_flag <= period_timer_flag_d;
			clock_fail_flag   <= clk_fail_q;
		end
	end

	// ---------------------------------------------------------------
	// register read
	// ---------------------------------------------------------------
	// one output flop shared by every register keeps the read port glitch free
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= REG_RESET;
		end else begin
			unique case (reg_addr)
				ADDR_AUTO_SHUTDOWN: reg_rdata <= as_ctl_q;
				ADDR_DEADBAND:      reg_rdata <= db_ctl_q;
				ADDR_MODE:          reg_rdata <= mode_q;
				ADDR_PERIOD:        reg_rdata <= period_q;
				ADDR_DUTY:          reg_rdata <= duty_q;
				ADDR_STATUS:        reg_rdata <= {6'h00, clk_fail_q, tmr_flag_q};
				ADDR_POWER:         reg_rdata <= {7'h00, sleep_q};
				default:            reg_rdata <= REG_RESET;
			endcase
		end
	end
endmodule : pas_top

/* File: sim/pas_top_monitor.sv */
// checker for pas_top: shutdown pin states, sticky flags, reset state
`timescale 1ns/10ps
module pas_top_monitor
	import pas_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       fault_input_n,
	input wire logic       comp1_out,
	input wire logic       comp2_out,
	input wire logic       clock_fail,
	input wire logic       pwm_out_a,
	input wire logic       pwm_out_b,
	input wire logic       pwm_out_c,
	input wire logic       pwm_out_d,
	input wire logic       pwm_oe_a,
	input wire logic       pwm_oe_b,
	input wire logic       pwm_oe_c,
	input wire logic       pwm_oe_d,
	input wire logic       period_timer_flag,
	input wire logic       clock_fail_flag,
	input wire logic       use_internal_osc
);
	// ----
	// shadow of written configuration
	// ----
	logic [7:0] asc_q;
	logic       en_q;
	logic       sd;
	logic       st_wr;
	always_ff @(posedge sys_clk) begin
		if (rst)
			asc_q <= REG_RESET;
		else if (reg_wr && reg_addr == ADDR_AUTO_SHUTDOWN)
			asc_q <= reg_wdata;
	end
	always_ff @(posedge sys_clk) begin
		if (rst)
			en_q <= 1'b0;
		else if (reg_wr && reg_addr == ADDR_MODE)
			en_q <= reg_wdata[PWMEN_HI:PWMEN_LO] == PWM_ENABLE_CODE;
	end
	// hardware causes only; a software force is judged by the bench
	assign sd = en_q && ((asc_q[SRC_LO + SRC_C1] && comp1_out) || (asc_q[SRC_LO + SRC_C2] && comp2_out)
		|| (asc_q[SRC_LO + SRC_FLT] && !fault_input_n));
	assign st_wr = reg_wr && reg_addr == ADDR_STATUS;
	// ----
	// assertions
	// ----
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence s_trip_ac(logic [1:0] code);
		sd && asc_q[PSAC_HI:PSAC_LO] == code;
	endsequence
	sequence s_trip_bd(logic [1:0] code);
		sd && asc_q[PSBD_HI:PSBD_LO] == code;
	endsequence
	chk_ac_high: assert property (s_trip_ac(PSS_HIGH) |=> pwm_out_a && pwm_out_c)
		else $error("pair ac not high in shutdown");
	chk_ac_low: assert property (s_trip_ac(PSS_LOW) |=> !pwm_out_a && !pwm_out_c)
		else $error("pair ac not low in shutdown");
	chk_bd_high: assert property (s_trip_bd(PSS_HIGH) |=> pwm_out_b && pwm_out_d)
		else $error("pair bd not high in shutdown");
	chk_ac_tri: assert property (sd && asc_q[PSAC_HI] |=> !pwm_oe_a && !pwm_oe_c)
		else $error("pair ac driven in tri-state shutdown");
	chk_bd_tri: assert property (sd && asc_q[PSBD_HI] |=> !pwm_oe_b && !pwm_oe_d)
		else $error("pair bd driven in tri-state shutdown");
	chk_reset_quiet: assert property ($fell(rst) |-> !(pwm_oe_a || pwm_oe_b || pwm_oe_c || pwm_oe_d)
		&& !period_timer_flag && !clock_fail_flag && !use_internal_osc)
		else $error("outputs not quiet after reset");
	chk_clkfail_set: assert property (clock_fail |-> ##[1:2] (clock_fail_flag && use_internal_osc))
		else $error("clock failure not flagged");
	chk_osc_sticky: assert property (use_internal_osc |=> use_internal_osc)
		else $error("internal oscillator selection dropped");
	chk_tmr_sticky: assert property (period_timer_flag && !st_wr && !$past(st_wr) |=> period_timer_flag)
		else $error("period flag dropped without clear");
endmodule : pas_top_monitor

bind pas_top pas_top_monitor i_pas_top_monitor (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .fault_input_n,
	.comp1_out, .comp2_out, .clock_fail, .pwm_out_a, .pwm_out_b, .pwm_out_c, .pwm_out_d, .pwm_oe_a, .pwm_oe_b,
	.pwm_oe_c, .pwm_oe_d, .period_timer_flag, .clock_fail_flag, .use_internal_osc);

/* File: sim/pas_bridge_model.sv */
// bridge fault sensing model: fault line and two current comparators
`timescale 1ns/10ps
module pas_bridge_model (
	input  wire logic       sys_clk,
	input  wire logic [2:0] trip_req,
	input  wire logic       slow,
	output logic            fault_input_n,
	output logic            comp1_out,
	output logic            comp2_out
);
	logic [2:0] req_q;
	initial begin
		req_q = 3'h0;
		comp1_out = 1'b0;
		comp2_out = 1'b0;
		fault_input_n = 1'b1;
	end
	// slow sensing adds a cycle, as a filtered current sense would
	always @(posedge sys_clk) begin
		req_q <= trip_req;
		comp1_out <= slow ? req_q[0] : trip_req[0];
		comp2_out <= slow ? req_q[1] : trip_req[1];
		fault_input_n <= !(slow ? req_q[2] : trip_req[2]);
	end
endmodule : pas_bridge_model

/* File: sim/pas_top_test.sv */
// self-checking bench for pas_top with the bridge sensing model
`timescale 1ns/10ps
module pas_top_test
	import pas_pkg::*;
;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       clock_fail = 1'b0;
	logic [2:0] trip_req = 3'h0;
	logic       slow = 1'b0;
	logic [7:0] reg_rdata;
	logic       fault_input_n, comp1_out, comp2_out;
	logic [7:0] pins;
	logic       period_timer_flag, clock_fail_flag, use_internal_osc;
	int         err_count = 0;
	int         num_checks = 0;

	pas_top i_pas_top (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fault_input_n,
		.comp1_out, .comp2_out, .clock_fail, .pwm_out_a(pins[0]), .pwm_out_b(pins[1]), .pwm_out_c(pins[2]),
		.pwm_out_d(pins[3]), .pwm_oe_a(pins[4]), .pwm_oe_b(pins[5]), .pwm_oe_c(pins[6]), .pwm_oe_d(pins[7]),
		.period_timer_flag, .clock_fail_flag, .use_internal_osc);
	pas_bridge_model i_pas_bridge_model (.sys_clk, .trip_req, .slow, .fault_input_n, .comp1_out, .comp2_out);

	always #25 sys_clk = ~sys_clk;

	// ----
	// helpers
	// ----
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got, input logic [7:0] m = 8'hff);
		num_checks++;
		if ((got & m) !== (exp & m)) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp & m, got & m);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, exp, reg_rdata, m);
	endtask : rchk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	// {mask, value} over {oe d c b a, out d c b a}; tri-state pairs judged by enable only
	function automatic logic [15:0] sd_pins(input logic [3:0] p);
		return {4'hf, !p[1], !p[3], !p[1], !p[3], !p[1], !p[3], !p[1], !p[3], p[0], p[2], p[0], p[2]};
	endfunction : sd_pins

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		for (int a = 0; a < 8; a++)
			rchk("reset value", 4'(a), REG_RESET);
		wr(ADDR_DEADBAND, 8'hd5);
		rchk("deadband", ADDR_DEADBAND, 8'hd5);
	endtask : t_reset
	task automatic t_first_period;
		int n;
		wr(ADDR_PERIOD, 8'h03);
		wr(ADDR_DUTY, 8'h02);
		wr(ADDR_MODE, {CFG_FWD, 2'h0, PWM_ENABLE_CODE, 2'h0});
		cyc(1);
		chk("flag before first period", 8'h00, {7'h00, period_timer_flag});
		n = 0;
		while (period_timer_flag !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		rchk("timer flag", ADDR_STATUS, 8'h01, 8'h01);
	endtask : t_first_period
	task automatic t_sources;
		logic [3:0]  pss;
		logic [15:0] e;
		wr(ADDR_DEADBAND, 8'h80);
		for (int c = 1; c < 8; c++)
			for (int s = 0; s < 3; s++) begin
				pss = 4'(c * 3 + s * 7);
				e = sd_pins(pss);
				wr(ADDR_AUTO_SHUTDOWN, {1'b0, 3'(c), pss});
				slow <= s[0];
				trip_req <= 3'(1 << s);
				cyc(4);
				if (c[s])
					chk("shutdown pins", e[7:0], pins, e[15:8]);
				rchk("status on event", ADDR_AUTO_SHUTDOWN, {c[s], 3'(c), pss});
				@(posedge sys_clk);
				trip_req <= 3'h0;
				cyc(40);
				rchk("status auto clear", ADDR_AUTO_SHUTDOWN, {1'b0, 3'(c), pss});
			end
	endtask : t_sources
	task automatic t_latch;
		wr(ADDR_DEADBAND, 8'h00);
		wr(ADDR_AUTO_SHUTDOWN, 8'h75);
		trip_req <= 3'h4;
		cyc(4);
		@(posedge sys_clk);
		trip_req <= 3'h0;
		cyc(40);
		rchk("status kept", ADDR_AUTO_SHUTDOWN, 8'hf5);
		chk("pins held", 8'h0f, pins, 8'h0f);
		@(posedge sys_clk);
		trip_req <= 3'h1;
		cyc(4);
		wr(ADDR_AUTO_SHUTDOWN, 8'h75);
		rchk("clear refused", ADDR_AUTO_SHUTDOWN, 8'hf5);
		@(posedge sys_clk);
		trip_req <= 3'h0;
		cyc(4);
		wr(ADDR_AUTO_SHUTDOWN, 8'h75);
		rchk("status cleared", ADDR_AUTO_SHUTDOWN, 8'h75);
		cyc(40);
		chk("pins resumed", 8'hf1, pins, 8'hf7);
	endtask : t_latch
	task automatic t_force;
		logic [15:0] e;
		e = sd_pins(4'h9);
		wr(ADDR_AUTO_SHUTDOWN, 8'h89);
		cyc(3);
		chk("forced pins", e[7:0], pins, e[15:8]);
		rchk("forced status", ADDR_AUTO_SHUTDOWN, 8'h89);
		wr(ADDR_AUTO_SHUTDOWN, 8'h09);
		rchk("force cleared", ADDR_AUTO_SHUTDOWN, 8'h09);
	endtask : t_force
	task automatic t_clock_fail;
		@(posedge sys_clk);
		clock_fail <= 1'b1;
		@(posedge sys_clk);
		clock_fail <= 1'b0;
		cyc(3);
		chk("clock fail", 8'h03, {6'h0, clock_fail_flag, use_internal_osc});
		rchk("clock fail status", ADDR_STATUS, 8'h02, 8'h02);
	endtask : t_clock_fail
	task automatic t_sleep;
		logic [7:0] p;
		wr(ADDR_POWER, 8'h01);
		cyc(2);
		p = pins;
		for (int i = 0; i < 8; i++) begin
			cyc(5);
			chk("frozen pins", p, pins);
		end
		wr(ADDR_POWER, 8'h00);
	endtask : t_sleep

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_first_period();
		t_sources();
		t_latch();
		t_force();
		t_clock_fail();
		t_sleep();
		report_and_stop();
	end
	// whole run is about 1300 cycles; this is about fifteen times that
	initial begin
		#1000000;
		err_count++;
		report_and_stop();
	end
endmodule : pas_top_test
